// >>> common/mmu_resp_regs.vh
`ifndef MMU_RESP_REGS_VH
`define MMU_RESP_REGS_VH

// register byte offsets
`define OFS_S1_CTRL      12'h000
`define OFS_S2_CTRL      12'h004
`define OFS_WALK_S1      12'h008
`define OFS_WALK_S2      12'h00C
`define OFS_FAULT_ADDR   12'h010
`define OFS_ABORT_STAT   12'h014

// translation control fields
`define CTL_HA           0
`define CTL_HD           1
`define CTL_S2_ON        4
`define CTL_AE_LO        8
`define CTL_AE_HI        11

// abort status fields
`define ST_ASYNC         0
`define ST_SYNC          1
`define ST_FSC_LO        8
`define ST_FSC_HI        13
`define ST_INSTR         16

// reset values
`define RST_CTRL         12'h000
`define RST_ATTR         4'h0
`define RST_ADDR         32'h0000_0000
`define RST_FSC          6'h00
`define RST_ZERO32       32'h0000_0000

// fault status codes
`define FSC_NONE         6'h00
`define FSC_ADDR_SIZE    6'h00
`define FSC_XLAT         6'h04
`define FSC_ACCESS       6'h08
`define FSC_PERM         6'h0C
`define FSC_EXT_SYNC     6'h10
`define FSC_HW_UPD       6'h31

// external abort operation codes
`define OP_WALK          3'h0
`define OP_LD_NORMAL     3'h1
`define OP_LD_DEVICE     3'h2
`define OP_STORE         3'h3
`define OP_CMO           3'h4
`define OP_TLBI          3'h5
`define OP_ICINV         3'h6

// cacheability and device kind codes
`define CA_NC            2'h0
`define CA_WT            2'h1
`define CA_WB            2'h2
`define DEV_GRE          2'h0
`define DEV_NGRE         2'h1
`define DEV_NGNRE        2'h2
`define DEV_NGNRNE       2'h3

`endif

// >>> rtl/mmu_response_attribute_logic.v
// How it works
// - table flag and dirty updates only in inner and outer write-back tables
// - disallowed table update on a data access aborts with code 110001
// - disallowed table update on a fetch aborts with code 110001
// - per-stage update enables; dirty update needs the dirty_bit_modifier
// - a response goes out after an l1 hit, l2 hit or table walk
// - response holds address, permissions, secure state and abort details
// - address size, translation, access flag, permission faults are raised
// - bus errors and uncorrected ecc errors are external aborts
// - walk, load normal and load device aborts are reported synchronously
// - synchronous external abort captures the target address
// - store, maintenance and invalidate aborts are reported asynchronously
// - contiguous hint outside the input range is ignored, no fault
// - tlb conflict aborts are never produced
// - gather-reorder-early device acts as non-cacheable, never speculative
// - no-early-ack device handled as early-ack inside, distinct on bus
// - write-through is not data cached and makes no coherency request
// - data caching only for inner and outer write-back memory type
// - up to four page attribute bits go out; disabled bits are zero
// - table walk accesses take attribute bits from walk controls
// - stage 2 enabled bit wins when stage 2 is on, then stage 1 enabled bit, else zero
// - attribute enables are judged bit by bit
`timescale 1ns/1ps
`default_nettype none
`include "mmu_resp_regs.vh"

module mmu_response_attribute_logic (
	// clock and reset
	input  wire        pclk,
	input  wire        presetn,
	// apb slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata_ff,
	output reg         pready_ff,
	output reg         pslverr_ff,
	// translation result from tlb or walker
	input  wire        tr_valid,
	input  wire        tr_is_instr,
	input  wire [1:0]  tr_src,
	input  wire [31:0] tr_pa,
	input  wire [3:0]  tr_perm,
	input  wire        tr_ns,
	input  wire        tr_stage2,
	input  wire        tr_write,
	input  wire        tr_af,
	input  wire        tr_dirty_bit_modifier,
	input  wire        tr_readonly,
	input  wire        tr_tbl_wb,
	input  wire        tr_addr_size_flt,
	input  wire        tr_xlat_flt,
	input  wire        tr_perm_flt,
	input  wire        tr_contiguous_hint_bit,
	input  wire        tr_range_covered,
	// translation responses
	output reg         iresp_valid_ff,
	output reg         dresp_valid_ff,
	output reg  [1:0]  resp_src_ff,
	output reg  [31:0] resp_pa_ff,
	output reg  [3:0]  resp_perm_ff,
	output reg         resp_ns_ff,
	output reg         resp_abort_ff,
	output reg  [5:0]  resp_fsc_ff,
	output reg         resp_contig_ff,
	// descriptor update request
	output reg         upd_valid_ff,
	output reg         upd_set_af_ff,
	output reg         upd_set_dirty_ff,
	// external error report
	input  wire        ea_valid,
	input  wire        ea_ecc,
	input  wire [2:0]  ea_op,
	input  wire        ea_is_instr,
	input  wire [31:0] ea_addr,
	// external abort reports
	output reg         sync_abort_ff,
	output reg         sync_abort_instr_ff,
	output reg         sync_abort_ecc_ff,
	output reg         async_abort_ff,
	// bus transaction attributes in
	input  wire        tx_valid,
	input  wire        tx_walk,
	input  wire        tx_walk_stage2,
	input  wire [3:0]  tx_s1_attr,
	input  wire [3:0]  tx_s2_attr,
	input  wire        tx_is_instr,
	input  wire        tx_spec,
	input  wire        tx_device,
	input  wire [1:0]  tx_dev_kind,
	input  wire [1:0]  tx_inner,
	input  wire [1:0]  tx_outer,
	// bus transaction attributes out
	output reg         bus_valid_ff,
	output reg  [3:0]  bus_page_attr_bits_ff,
	output reg         bus_device_ff,
	output reg  [1:0]  bus_dev_kind_ff,
	output reg         bus_gather_ff,
	output reg         bus_strict_order_ff,
	output reg         bus_cacheable_ff,
	output reg         bus_coherent_ff,
	output reg         tx_blocked_ff
);

	// ********************************************************
	// register file
	// ********************************************************
	reg  [11:0] stage1_translation_control_ff;
	reg  [11:0] stage2_translation_control_ff;
	reg  [3:0]  walk_attr_control_stage1_ff;
	reg  [3:0]  walk_attr_control_stage2_ff;
	reg  [31:0] fault_address_reg_ff;
	reg         st_async_ff;
	reg         st_sync_ff;
	reg  [5:0]  st_fsc_ff;
	reg         st_instr_ff;

	reg  [31:0] nxt_rdata;
	reg         nxt_err;
	wire        wr_acc = psel & penable & pready_ff & pwrite;

	// read mux; unmapped offsets read zero with slave error
	always @*
	begin
		nxt_rdata = `RST_ZERO32;
		nxt_err   = 1'b0;
		if (paddr == `OFS_S1_CTRL)
			nxt_rdata[11:0] = stage1_translation_control_ff;
		else if (paddr == `OFS_S2_CTRL)
			nxt_rdata[11:0] = stage2_translation_control_ff;
		else if (paddr == `OFS_WALK_S1)
			nxt_rdata[3:0] = walk_attr_control_stage1_ff;
		else if (paddr == `OFS_WALK_S2)
			nxt_rdata[3:0] = walk_attr_control_stage2_ff;
		else if (paddr == `OFS_FAULT_ADDR)
			nxt_rdata = fault_address_reg_ff;
		else if (paddr == `OFS_ABORT_STAT)
		begin
			nxt_rdata[`ST_ASYNC] = st_async_ff;
			nxt_rdata[`ST_SYNC]  = st_sync_ff;
			nxt_rdata[`ST_FSC_HI:`ST_FSC_LO] = st_fsc_ff;
			nxt_rdata[`ST_INSTR] = st_instr_ff;
		end
		else
			nxt_err = 1'b1;
	end

	// no wait state: ready rises in the first access cycle only
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_ff  <= 1'b0;
			prdata_ff  <= `RST_ZERO32;
			pslverr_ff <= 1'b0;
		end
		else
		begin
			pready_ff  <= psel & ~penable;
			pslverr_ff <= psel & ~penable & nxt_err;
			if (psel & ~penable & ~pwrite)
				prdata_ff <= nxt_rdata;
			else
				prdata_ff <= `RST_ZERO32;
		end
	end

	// software written control registers
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			stage1_translation_control_ff <= `RST_CTRL;
			stage2_translation_control_ff <= `RST_CTRL;
			walk_attr_control_stage1_ff   <= `RST_ATTR;
			walk_attr_control_stage2_ff   <= `RST_ATTR;
		end
		else if (wr_acc)
		begin
			if (paddr == `OFS_S1_CTRL)
				stage1_translation_control_ff <= pwdata[11:0];
			else if (paddr == `OFS_S2_CTRL)
				stage2_translation_control_ff <= pwdata[11:0];
			else if (paddr == `OFS_WALK_S1)
				walk_attr_control_stage1_ff <= pwdata[3:0];
			else if (paddr == `OFS_WALK_S2)
				walk_attr_control_stage2_ff <= pwdata[3:0];
		end
	end

	wire [11:0] s1c = stage1_translation_control_ff;
	wire [11:0] s2c = stage2_translation_control_ff;
	wire [3:0]  s1_attr_en = s1c[`CTL_AE_HI:`CTL_AE_LO];
	wire [3:0]  s2_attr_en = s2c[`CTL_AE_HI:`CTL_AE_LO];
	wire        s2_on = s2c[`CTL_S2_ON];

	// ********************************************************
	// translation response and hardware table update
	// ********************************************************
	// the stage that owns the descriptor chooses the update enables
	wire ha_en = tr_stage2 ? s2c[`CTL_HA] : s1c[`CTL_HA];
	wire hd_en = tr_stage2 ? s2c[`CTL_HD] : s1c[`CTL_HD];
	wire need_af  = ~tr_af & ha_en;
	wire need_drt = tr_write & tr_readonly & tr_dirty_bit_modifier
		& hd_en;
	wire need_upd = need_af | need_drt;
	wire upd_bad  = need_upd & ~tr_tbl_wb;

	reg        nxt_abort;
	reg  [5:0] nxt_fsc;

	// fault priority: size, translation, table update, flag, permission;
	// no conflict code exists here, overlapping entries never abort
	always @*
	begin
		nxt_abort = 1'b1;
		nxt_fsc   = `FSC_NONE;
		if (tr_addr_size_flt)
			nxt_fsc = `FSC_ADDR_SIZE;
		else if (tr_xlat_flt)
			nxt_fsc = `FSC_XLAT;
		else if (upd_bad)
			nxt_fsc = `FSC_HW_UPD;
		else if (~tr_af & ~ha_en)
			nxt_fsc = `FSC_ACCESS;
		else if (tr_perm_flt | (tr_write & tr_readonly & ~need_drt))
			nxt_fsc = `FSC_PERM;
		else
			nxt_abort = 1'b0;
	end

	wire nxt_ok_upd = tr_valid & need_upd & ~nxt_abort;

	// response routed back to whichever side asked, for every source
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			iresp_valid_ff   <= 1'b0;
			dresp_valid_ff   <= 1'b0;
			resp_src_ff      <= 2'b00;
			resp_pa_ff       <= `RST_ADDR;
			resp_perm_ff     <= 4'h0;
			resp_ns_ff       <= 1'b0;
			resp_abort_ff    <= 1'b0;
			resp_fsc_ff      <= `RST_FSC;
			resp_contig_ff   <= 1'b0;
			upd_valid_ff     <= 1'b0;
			upd_set_af_ff    <= 1'b0;
			upd_set_dirty_ff <= 1'b0;
		end
		else
		begin
			iresp_valid_ff <= tr_valid & tr_is_instr;
			dresp_valid_ff <= tr_valid & ~tr_is_instr;
			upd_valid_ff     <= nxt_ok_upd;
			upd_set_af_ff    <= nxt_ok_upd & need_af;
			upd_set_dirty_ff <= nxt_ok_upd & need_drt;
			if (tr_valid)
			begin
				resp_src_ff   <= tr_src;
				resp_pa_ff    <= tr_pa;
				resp_perm_ff  <= tr_perm;
				resp_ns_ff    <= tr_ns;
				resp_abort_ff <= nxt_abort;
				resp_fsc_ff   <= nxt_fsc;
				// a hint that overruns the range is dropped silently
				resp_contig_ff <= tr_contiguous_hint_bit
					& tr_range_covered;
			end
		end
	end

	// ********************************************************
	// external aborts
	// ********************************************************
	// bus error or ecc error both arrive here as one report
	wire ea_sync = ea_valid & ((ea_op == `OP_WALK)
		| (ea_op == `OP_LD_NORMAL)
		| (ea_op == `OP_LD_DEVICE));
	wire ea_async = ea_valid & ((ea_op == `OP_STORE)
		| (ea_op == `OP_CMO) | (ea_op == `OP_TLBI)
		| (ea_op == `OP_ICINV));

	wire clr_stat = wr_acc & (paddr == `OFS_ABORT_STAT);

	// sticky status; an abort in the clearing cycle wins over the clear
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sync_abort_ff        <= 1'b0;
			sync_abort_instr_ff  <= 1'b0;
			sync_abort_ecc_ff    <= 1'b0;
			async_abort_ff       <= 1'b0;
			fault_address_reg_ff <= `RST_ADDR;
			st_async_ff          <= 1'b0;
			st_sync_ff           <= 1'b0;
			st_fsc_ff            <= `RST_FSC;
			st_instr_ff          <= 1'b0;
		end
		else
		begin
			sync_abort_ff       <= ea_sync;
			sync_abort_instr_ff <= ea_sync & ea_is_instr;
			sync_abort_ecc_ff   <= ea_sync & ea_ecc;
			if (ea_sync)
			begin
				fault_address_reg_ff <= ea_addr;
				st_fsc_ff   <= `FSC_EXT_SYNC;
				st_instr_ff <= ea_is_instr;
			end
			else if (tr_valid & nxt_abort)
			begin
				st_fsc_ff   <= nxt_fsc;
				st_instr_ff <= tr_is_instr;
			end
			if (ea_async)
				st_async_ff <= 1'b1;
			else if (clr_stat & pwdata[`ST_ASYNC])
				st_async_ff <= 1'b0;
			if (ea_sync)
				st_sync_ff <= 1'b1;
			else if (clr_stat & pwdata[`ST_SYNC])
				st_sync_ff <= 1'b0;
			// async pending line follows its sticky bit
			if (ea_async)
				async_abort_ff <= 1'b1;
			else if (clr_stat & pwdata[`ST_ASYNC])
				async_abort_ff <= 1'b0;
		end
	end

	// ********************************************************
	// memory type and page attribute bits
	// ********************************************************
	reg  [3:0] nxt_attr;
	wire       wb_both = (tx_inner == `CA_WB) & (tx_outer == `CA_WB);
	wire       wt_any  = (tx_inner == `CA_WT) | (tx_outer == `CA_WT);
	wire       no_spec_dev = tx_spec & tx_device;
	wire       dev_strict = (tx_dev_kind == `DEV_NGNRE)
		| (tx_dev_kind == `DEV_NGNRNE);

	// attributes combine bit by bit; walks take the walk controls
	always @*
	begin
		nxt_attr = 4'h0;
		if (tx_walk)
			nxt_attr = tx_walk_stage2 ? walk_attr_control_stage2_ff
				: walk_attr_control_stage1_ff;
		else if (s2_on)
			nxt_attr = (s2_attr_en & tx_s2_attr)
				| (~s2_attr_en & s1_attr_en & tx_s1_attr);
		else
			nxt_attr = s1_attr_en & tx_s1_attr;
	end

	// ordering of reordering device types is left to software barriers
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			bus_valid_ff          <= 1'b0;
			bus_page_attr_bits_ff <= 4'h0;
			bus_device_ff         <= 1'b0;
			bus_dev_kind_ff       <= `DEV_GRE;
			bus_gather_ff         <= 1'b0;
			bus_strict_order_ff   <= 1'b0;
			bus_cacheable_ff      <= 1'b0;
			bus_coherent_ff       <= 1'b0;
			tx_blocked_ff         <= 1'b0;
		end
		else
		begin
			bus_valid_ff  <= tx_valid & ~no_spec_dev;
			tx_blocked_ff <= tx_valid & no_spec_dev;
			if (tx_valid & ~no_spec_dev)
			begin
				bus_page_attr_bits_ff <= nxt_attr;
				// fetches see device pages as non-device non-cacheable; gather still follows the device kind
				bus_device_ff   <= tx_device & ~tx_is_instr;
				bus_dev_kind_ff <= tx_dev_kind;
				bus_gather_ff   <= ~tx_device
					| (tx_dev_kind == `DEV_GRE);
				bus_strict_order_ff <= tx_device & ~tx_is_instr
					& dev_strict;
				if (tx_is_instr)
					bus_cacheable_ff <= ~tx_device
						& (wb_both | wt_any);
				else
					bus_cacheable_ff <= ~tx_device & wb_both;
				bus_coherent_ff <= ~tx_is_instr & ~tx_device
					& wb_both;
			end
		end
	end

endmodule // mmu_response_attribute_logic

`default_nettype wire

// >>> test/mmu_resp_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ********************************
// response and abort timing checks
// ********************************
module mmu_resp_chk (
	// clock and reset
	input wire logic       pclk,
	input wire logic       presetn,
	// translation
	input wire logic       tr_valid,
	input wire logic       tr_is_instr,
	input wire logic       iresp_valid_ff,
	input wire logic       dresp_valid_ff,
	// external errors
	input wire logic       ea_valid,
	input wire logic [2:0] ea_op,
	input wire logic       sync_abort_ff,
	input wire logic       async_abort_ff,
	// bus transactions
	input wire logic       tx_valid,
	input wire logic       tx_spec,
	input wire logic       tx_device,
	input wire logic       bus_valid_ff,
	input wire logic       tx_blocked_ff
);
	// one domain, so clock and reset are stated once
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// each response is tied to its cause one cycle earlier
	a_fetch_resp:
		assert property (tr_valid && tr_is_instr
			|=> iresp_valid_ff && !dresp_valid_ff)
		else $error("fetch response missing");
	a_data_resp:
		assert property (tr_valid && !tr_is_instr
			|=> dresp_valid_ff && !iresp_valid_ff)
		else $error("data response missing");
	a_resp_cause:
		assert property (iresp_valid_ff || dresp_valid_ff
			|-> $past(tr_valid))
		else $error("response without a request");
	a_sync_abort:
		assert property (ea_valid && ea_op < 3'h3 |=> sync_abort_ff)
		else $error("synchronous abort missing");
	a_sync_cause:
		assert property (sync_abort_ff
			|-> $past(ea_valid && ea_op < 3'h3))
		else $error("synchronous abort from wrong source");
	a_async_flag:
		assert property (ea_valid && ea_op inside {[3'h3:3'h6]}
			|=> async_abort_ff)
		else $error("asynchronous abort missing");
	a_spec_block:
		assert property (tx_valid && tx_spec && tx_device
			|=> tx_blocked_ff && !bus_valid_ff)
		else $error("speculative device access issued");
	a_bus_issue:
		assert property (tx_valid && !(tx_spec && tx_device)
			|=> bus_valid_ff && !tx_blocked_ff)
		else $error("bus transaction missing");

	// main scenarios reached
	c_data: cover property (dresp_valid_ff);
	c_sync: cover property (sync_abort_ff);
	c_block: cover property (tx_blocked_ff);
endmodule // mmu_resp_chk
`default_nettype wire

// >>> test/resp_sink.sv
`timescale 1ns/1ps
`default_nettype none
// ********************************
// requester side response tally
// ********************************
module resp_sink (
	// clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// responses from the block
	input  wire logic iresp_valid_ff,
	input  wire logic dresp_valid_ff,
	// tallies for the bench
	output var  int   n_fetch,
	output var  int   n_data
);
	// a lost or doubled pulse shows up as a count off by one
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			n_fetch <= 0;
			n_data <= 0;
		end
		else
		begin
			n_fetch <= n_fetch + int'(iresp_valid_ff);
			n_data <= n_data + int'(dresp_valid_ff);
		end
	end
endmodule // resp_sink
`default_nettype wire

// >>> test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ********************************
// bench top
// ********************************
module tb_top;
	// driven inputs, packed so one assignment moves a whole request
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [51:0] trv = '0;
	logic [37:0] eav = '0;
	logic [19:0] txv = '0;
	logic [19:0] tv;
	logic [31:0] seed = 32'h536d_5a24;
	logic [31:0] rd, r32, c1, c2, w1, w2;
	logic        er, ha, hd, bl, wb, wt;
	int          mismatches = 0, checks = 0, nf_e = 0, nd_e = 0;
	int          n_fetch, n_data;
	wire [31:0] prdata_ff, tr_pa, resp_pa_ff, ea_addr;
	wire [3:0] tr_perm, resp_perm_ff, tx_s1_attr, tx_s2_attr;
	wire [3:0] bus_page_attr_bits_ff;
	wire [1:0] tr_src, resp_src_ff, tx_dev_kind, tx_inner, tx_outer;
	wire [1:0] bus_dev_kind_ff;
	wire [5:0] resp_fsc_ff;
	wire [2:0] ea_op;
	wire pready_ff, pslverr_ff, tr_valid, tr_is_instr, tr_ns, tr_stage2,
		tr_write, tr_af, tr_dirty_bit_modifier, tr_readonly, tr_tbl_wb,
		tr_addr_size_flt, tr_xlat_flt, tr_perm_flt, tr_contiguous_hint_bit,
		tr_range_covered, iresp_valid_ff, dresp_valid_ff, resp_ns_ff,
		resp_abort_ff, resp_contig_ff, upd_valid_ff, upd_set_af_ff,
		upd_set_dirty_ff, ea_valid, ea_ecc, ea_is_instr, sync_abort_ff,
		sync_abort_instr_ff, sync_abort_ecc_ff, async_abort_ff, tx_valid,
		tx_walk, tx_walk_stage2, tx_is_instr, tx_spec, tx_device,
		bus_valid_ff, bus_device_ff, bus_gather_ff, bus_strict_order_ff,
		bus_cacheable_ff, bus_coherent_ff, tx_blocked_ff;

	// unpack the request vectors onto the ports
	assign {tr_valid, tr_is_instr, tr_src, tr_pa, tr_perm, tr_ns, tr_stage2,
		tr_write, tr_af, tr_dirty_bit_modifier, tr_readonly, tr_tbl_wb,
		tr_addr_size_flt, tr_xlat_flt, tr_perm_flt, tr_contiguous_hint_bit,
		tr_range_covered} = trv;
	assign {ea_valid, ea_ecc, ea_op, ea_is_instr, ea_addr} = eav;
	assign {tx_valid, tx_walk, tx_walk_stage2, tx_s1_attr, tx_s2_attr,
		tx_is_instr, tx_spec, tx_device, tx_dev_kind, tx_inner,
		tx_outer} = txv;

	// clock, design and requester model
	always #4 pclk = ~pclk;
	mmu_response_attribute_logic dut (.*);
	resp_sink u_sink (.*);

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// {valid, fetch, src, pa, perm, flags}, flags from ns down to covered
	function automatic logic [51:0] mk(input logic i, input logic [11:0] f);
		logic [31:0] a;
		a = rnd();
		return {1'b1, i, a[1:0], rnd(), a[7:4], f};
	endfunction

	// {abort, code}; an update ranks above the flag and permission faults
	function automatic logic [6:0] fexp(input logic [11:0] f);
		logic nd;
		nd = (!f[8] & ha) | (f[9] & f[6] & f[7] & hd);
		if (f[4])
			return 7'h40;
		if (f[3])
			return 7'h44;
		if (nd & !f[5])
			return 7'h71;
		if (!f[8] & !ha)
			return 7'h48;
		if (f[2] | (f[9] & f[6] & !(f[7] & hd)))
			return 7'h4c;
		return 7'h00;
	endfunction

	function automatic logic [3:0] aexp(input logic [19:0] v);
		if (v[18])
			return v[17] ? w2[3:0] : w1[3:0];
		if (c2[4])
			return (c2[11:8] & v[12:9]) | (~c2[11:8] & c1[11:8] & v[16:13]);
		return c1[11:8] & v[16:13];
	endfunction

	task automatic chk(input string n, input logic [63:0] s, input logic [63:0] x);
		checks++;
		if (s !== x)
		begin
			mismatches++;
			$display("CHECK FAILED %s expected %0h seen %0h", n, x, s);
		end
	endtask

	// the request stands until pready is seen high at an edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready_ff !== 1'b1);
		rd = prdata_ff;
		er = pslverr_ff;
		psel <= 1'b0;
		penable <= 1'b0;
		#1;
	endtask

	task automatic xl(input logic [51:0] v, input logic [3:0] u);
		logic [6:0] x;
		x = fexp(v[11:0]);
		@(posedge pclk);
		trv <= v;
		@(posedge pclk);
		trv <= '0;
		#1;
		nf_e += v[50];
		nd_e += !v[50];
		chk("abort", {resp_abort_ff, resp_fsc_ff},
			x);
		chk("resp", {iresp_valid_ff, dresp_valid_ff},
			{v[50], !v[50]});
		chk("pa", resp_pa_ff, v[47:16]);
		// source tag, then permissions and secure state
		chk("echo", {resp_src_ff, resp_perm_ff, resp_ns_ff},
			{v[49:48], v[15:11]});
		chk("contig", resp_contig_ff, v[1] & v[0]);
		if (u[3])
			chk("update", {upd_valid_ff, upd_set_af_ff,
				upd_set_dirty_ff}, u[2:0]);
	endtask

	task automatic test_done();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// a hang counts as a mismatch
	initial
	begin
		#500000;
		mismatches++;
		test_done();
	end

	// main sequence
	initial
	begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 7; i++)
		begin
			apb(1'b0, 12'(i * 4), 32'h0000_0000);
			chk("reg", {er, rd}, {i == 6, 32'h0000_0000});
		end
		ha = 1'b1;
		hd = 1'b1;
		apb(1'b1, 12'h000, 32'h0000_0003);
		apb(1'b1, 12'h004, 32'h0000_0003);
		xl(mk(1'b1, 12'h000), 4'h8);
		xl(mk(1'b0, 12'h000), 4'h8);
		// write-back tables: flag set allowed, then dirty set allowed
		xl(mk(1'b0, 12'h020), 4'he);
		xl(mk(1'b0, 12'h3e0), 4'hd);
		xl(mk(1'b0, 12'h102), 4'h8);
		// dirty update switched off: a clean write is refused instead
		hd = 1'b0;
		apb(1'b1, 12'h000, 32'h0000_0001);
		apb(1'b1, 12'h004, 32'h0000_0001);
		xl(mk(1'b0, 12'h3e0), 4'h8);
		for (int i = 0; i < 40; i++)
		begin
			r32 = rnd();
			xl(mk(r32[12], r32[11:0]), 4'h0);
		end
		// the sink tallies the last pulse one edge after it shows
		@(posedge pclk);
		#1;
		chk("sink", {n_fetch, n_data}, {nf_e, nd_e});
		// every error source, both kinds of error
		for (int op = 0; op < 7; op++)
		begin
			r32 = rnd();
			@(posedge pclk);
			eav <= {1'b1, r32[0], 3'(op), r32[1], r32};
			@(posedge pclk);
			eav <= '0;
			#1;
			chk("sync", {sync_abort_ff, sync_abort_instr_ff, sync_abort_ecc_ff},
				(op < 3) ? {1'b1, r32[1], r32[0]} : 3'h0);
			chk("async", async_abort_ff, op > 2);
			if (op < 3)
			begin
				apb(1'b0, 12'h010, 32'h0000_0000);
				chk("fault addr", rd, r32);
			end
			else
			begin
				apb(1'b1, 12'h014, 32'h0000_0001);
				chk("async clear", async_abort_ff, 1'b0);
			end
		end
		// bus attributes, every device kind in turn
		for (int i = 0; i < 64; i++)
		begin
			if (i % 8 == 0)
			begin
				c1 = rnd() & 32'h0000_0f00;
				c2 = rnd() & 32'h0000_0f10;
				w1 = rnd() & 32'h0000_000f;
				w2 = rnd() & 32'h0000_000f;
				apb(1'b1, 12'h000, c1);
				apb(1'b1, 12'h004, c2);
				apb(1'b1, 12'h008, w1);
				apb(1'b1, 12'h00c, w2);
			end
			r32 = rnd();
			tv = {1'b1, r32[18:6], i[1:0], r32[3:0]};
			@(posedge pclk);
			txv <= tv;
			@(posedge pclk);
			// one access at a time stands in for barriers
			txv <= '0;
			#1;
			bl = tv[7] & tv[6];
			wb = tv[3:2] == 2'h2 && tv[1:0] == 2'h2;
			wt = tv[3:2] == 2'h1 || tv[1:0] == 2'h1;
			chk("issue", {bus_valid_ff, tx_blocked_ff},
				{!bl, bl});
			if (!bl)
			begin
				chk("page attr", bus_page_attr_bits_ff,
					aexp(tv));
				chk("device", {bus_device_ff, bus_dev_kind_ff, bus_gather_ff,
					bus_strict_order_ff}, {tv[6] & !tv[8], tv[5:4],
					!tv[6] | tv[5:4] == 2'h0,
					tv[6] & !tv[8] & tv[5]});
				chk("cache", {bus_cacheable_ff, bus_coherent_ff},
					{!tv[6] & (wb | tv[8] & wt),
					!tv[6] & !tv[8] & wb});
			end
		end
		test_done();
	end
endmodule // tb_top

bind mmu_response_attribute_logic mmu_resp_chk u_chk (.*);
`default_nettype wire
